// *** hdl/uart_infrared_codec.sv ***
// infrared encoder and decoder between a uart and its pins
`default_nettype none
// Function
// - bit rate is clock over sixteen times divisor
// - every bit is sixteen baud ticks long
// - a one sends low for whole bit
// - a zero sends 7 low, 3 high, 6 low
// - encoder uses uart transmit and baud tick
// - enabled, transmit pin carries modulated output
// - enabled, receive pin feeds decoder to uart
// - decoder samples input on baud ticks
// - standard infrared rates 9600 to 115200 baud
// - decoded bits after first are sixteen ticks
// - enable bit routes both directions through codec
module uart_infrared_codec (
    input  wire logic                        ref_clk,
    input  wire logic                        srst,
    input  wire logic                        ir_codec_enable,
    input  wire logic [ir_codec_pkg::DIV_W-1:0] baud_divisor,
    input  wire logic                        uart_txd,
    output logic                             uart_rxd,
    output logic                             baud_tick,
    output logic                             txd_pin,
    input  wire logic                        rxd_pin
);
    import ir_codec_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div_cnt;   // baud divisor down counter
        logic             tick;      // one-cycle baud clock pulse
        logic [3:0]       tx_sub;    // tick index within transmit bit
        logic             tx_bit;    // bit latched at start of transmit bit
        logic             tx_busy;   // a zero has started a transmit frame
        logic             tx_out;    // modulated output
        logic             rx_sync;   // receive pin sampled on ticks
        logic             rx_act;    // decoder inside a bit window
        logic [3:0]       rx_sub;    // tick index within receive bit
        logic             rx_seen;   // pulse seen in current window
        logic             rx_bit;    // bit produced at window end
        logic             rx_push;   // request to buffer rx_bit
        logic             txd_q;     // transmit pin register
        logic             rxd_q;     // uart receive register
    } codec_state_t;

    codec_state_t         s_q;
    codec_state_t         s_d;
    logic                 fifo_in_ready;
    logic                 fifo_out_data;
    logic                 fifo_out_valid;
    logic                 fifo_pop;

    // shared bit-window counter step
    function automatic logic [3:0] next_sub(input logic [3:0] sub);
        next_sub = (sub == SUB_LAST) ? 4'h0 : sub + 4'h1;
    endfunction : next_sub

    // decoded bits wait here until the uart side takes one per bit slot
    assign fifo_pop = s_q.tick && (s_q.rx_sub == 4'h0);

    ir_bit_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_rx_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_data   (s_q.rx_bit),
        .in_valid  (s_q.rx_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    // next-state logic
    always_comb begin
        s_d         = s_q;
        s_d.rx_push = s_q.rx_push && !fifo_in_ready;
        // baud divisor: one tick every divisor clocks, sixteen per bit
        // any divisor runs; standard infrared rates are a subset
        s_d.tick    = 1'b0;
        if (s_q.div_cnt <= 16'h0001) begin
            s_d.div_cnt = (baud_divisor == '0) ? 16'h0001 : baud_divisor;
            s_d.tick    = 1'b1;
        end else begin
            s_d.div_cnt = s_q.div_cnt - 16'h0001;
        end

        // encoder: bit timing from uart transmit line and ticks
        if (s_q.tick) begin
            if (s_q.tx_busy || !uart_txd) begin
                if (s_q.tx_sub == 4'h0) begin
                    s_d.tx_bit = s_q.tx_busy ? uart_txd : 1'b0;
                end
                s_d.tx_busy = !(s_q.tx_sub == SUB_LAST && uart_txd);
                s_d.tx_sub  = next_sub(s_q.tx_sub);
            end
            // zero: high only on ticks seven to nine; one: stays low
            s_d.tx_out = 1'b0;
            if ((s_q.tx_busy || !uart_txd) &&
                ((s_q.tx_sub == 4'h0) ? !(s_q.tx_busy ? uart_txd : 1'b0) : !s_q.tx_bit) &&
                s_q.tx_sub >= PULSE_FIRST && s_q.tx_sub <= PULSE_LAST) begin
                s_d.tx_out = 1'b1;
            end
        end

        // decoder: sample pin on ticks, window of sixteen ticks per bit
        if (s_q.tick) begin
            s_d.rx_sync = rxd_pin;
            if (!s_q.rx_act) begin
                if (s_q.rx_sync) begin
                    s_d.rx_act  = 1'b1;                             // first bit may jitter
                    s_d.rx_seen = 1'b1;
                    s_d.rx_sub  = 4'h1;
                end
            end else begin
                s_d.rx_sub  = next_sub(s_q.rx_sub);
                s_d.rx_seen = s_q.rx_seen || s_q.rx_sync;
                if (s_q.rx_sub == SUB_LAST) begin
                    s_d.rx_bit  = !(s_q.rx_seen || s_q.rx_sync);
                    s_d.rx_push = 1'b1;
                    s_d.rx_seen = 1'b0;
                    s_d.rx_act  = s_q.rx_seen || s_q.rx_sync;
                end
            end
        end
        if (!ir_codec_enable) begin
            s_d.rx_act  = 1'b0;
            s_d.tx_busy = 1'b0;
            s_d.tx_sub  = 4'h0;
        end

        // pin routing
        if (ir_codec_enable) begin
            s_d.txd_q = s_q.tx_out;
            if (fifo_pop) begin
                s_d.rxd_q = fifo_out_valid ? fifo_out_data : 1'b1;
            end
        end else begin
            s_d.txd_q = uart_txd;
            s_d.rxd_q = rxd_pin;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q         <= '0;
            s_q.div_cnt <= DIV_RESET;
            s_q.tx_bit  <= 1'b1;
            s_q.rx_bit  <= 1'b1;
            s_q.txd_q   <= 1'b1;
            s_q.rxd_q   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign uart_rxd  = s_q.rxd_q;
    assign baud_tick = s_q.tick;
    assign txd_pin   = s_q.txd_q;
endmodule : uart_infrared_codec
`default_nettype wire

// *** inc/ir_codec_pkg.sv ***
// constants shared by the infrared codec
`default_nettype none
package ir_codec_pkg;
    localparam int unsigned     DIV_W         = 16;          // width of the baud divisor
    localparam logic [15:0]     DIV_RESET     = 16'hFFFF;    // divisor down counter value after reset
    localparam logic [3:0]      SUB_LAST      = 4'hF;        // sixteen baud ticks per bit
    localparam logic [3:0]      PULSE_FIRST   = 4'h7;        // high pulse starts after seven ticks
    localparam logic [3:0]      PULSE_LAST    = 4'h9;        // three ticks high
    localparam int unsigned     FIFO_W        = 1;           // one decoded bit per word
    localparam int unsigned     FIFO_D        = 16;          // words in the receive buffer
    localparam int unsigned     IR_MIN_BAUD   = 9600;        // lower standard infrared rate
    localparam int unsigned     IR_MAX_BAUD   = 115200;      // upper standard infrared rate
    localparam int unsigned     CLK_HZ        = 100000000;   // ref_clk rate
    localparam int unsigned     PERIOD_NS     = 10;          // ref_clk period
endpackage : ir_codec_pkg
`default_nettype wire

// *** hdl/ir_bit_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
`default_nettype none
module ir_bit_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic [WIDTH-1:0]   in_data,
    input  wire logic               in_valid,
    output logic                    in_ready,
    output logic      [WIDTH-1:0]   out_data,
    output logic                    out_valid,
    input  wire logic               out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } fifo_state_t;

    fifo_state_t          s_q;
    fifo_state_t          s_d;
    logic [WIDTH-1:0]     mem_q [DEPTH];
    logic                 push;
    logic                 pop;

    // handshakes and honest flags
    assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_q.cnt != '0);
    assign out_data  = mem_q[s_q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // register state and storage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
        if (push) begin
            mem_q[s_q.wr] <= in_data;
        end
    end
endmodule : ir_bit_fifo
`default_nettype wire

// *** tb/uart_infrared_codec_checker.sv ***
// assertions on the infrared codec ports
`default_nettype none
module uart_infrared_codec_checker (
    input wire logic                            ref_clk,
    input wire logic                            srst,
    input wire logic                            ir_codec_enable,
    input wire logic [ir_codec_pkg::DIV_W-1:0]  baud_divisor,
    input wire logic                            uart_txd,
    input wire logic                            uart_rxd,
    input wire logic                            baud_tick,
    input wire logic                            txd_pin,
    input wire logic                            rxd_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    import ir_codec_pkg::*;
    logic [7:0]  low_q, hi_q;
    logic [10:0] quiet_q, rlow_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // run lengths of line levels while the codec is on
    always_ff @(posedge ref_clk) begin
        if (srst || !ir_codec_enable) begin
            low_q   <= '0;
            hi_q    <= '0;
            quiet_q <= '0;
            rlow_q  <= '0;
        end else begin
            low_q   <= txd_pin ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
            hi_q    <= uart_txd ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
            quiet_q <= rxd_pin ? 11'h000 : quiet_q + {10'h000, quiet_q != 11'h7FF};
            rlow_q  <= uart_rxd ? 11'h000 : rlow_q + 11'h001;
        end
    end
    tx_pass_a: assert property (!ir_codec_enable && $past(!ir_codec_enable) && $past(!srst)
        |-> txd_pin == $past(uart_txd)) else $error("transmit pin not passing uart line");
    rx_pass_a: assert property (!ir_codec_enable && $past(!ir_codec_enable) && $past(!srst)
        |-> uart_rxd == $past(rxd_pin)) else $error("receive pin not passing to uart");
    tick_gap_a: assert property (baud_tick && baud_divisor == 16'h0004 && $past(baud_divisor) == 16'h0004
        |=> !baud_tick [*3] ##1 baud_tick) else $error("baud tick spacing wrong");
    pulse_len_a: assert property ($rose(txd_pin) && ir_codec_enable && baud_divisor == 16'h0004
        |-> txd_pin [*8] ##1 txd_pin [*4] ##1 !txd_pin) else $error("pulse not three ticks wide");
    pulse_lead_a: assert property ($rose(txd_pin) && ir_codec_enable |-> low_q >= 8'h34)
        else $error("pulse came too early in bit");
    one_dark_a: assert property (ir_codec_enable && hi_q == 8'hFF |-> !txd_pin)
        else $error("pulse sent for a one");
    rx_idle_a: assert property (ir_codec_enable && quiet_q == 11'h7FF |-> uart_rxd)
        else $error("zero decoded without pulse");
    rx_width_a: assert property ($rose(uart_rxd) && ir_codec_enable |-> rlow_q[5:0] == 6'h00)
        else $error("decoded zero not whole bits");
    cover property ($rose(txd_pin) && ir_codec_enable);
    cover property ($fell(uart_rxd) && ir_codec_enable);
    cover property (baud_tick ##4 baud_tick);
endmodule : uart_infrared_codec_checker
bind uart_infrared_codec uart_infrared_codec_checker chk (.*);
`default_nettype wire

// *** tb/ir_transceiver_model.sv ***
// infrared transceiver model flashing frames onto the receive pin
`default_nettype none
module ir_transceiver_model #(
    parameter int BIT_CLKS  = 64,
    parameter int PULSE_AT  = 28,
    parameter int PULSE_LEN = 12
) (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       go,
    input  wire logic [7:0] data,
    output logic            busy,
    output logic            rx_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] frame;
    int         cnt;
    // zero bits flash one short pulse, ones and idle stay dark
    always @(posedge ref_clk) begin
        if (srst) begin
            busy   <= 1'b0;
            rx_out <= 1'b0;
        end else if (!busy && go) begin
            frame <= {1'b1, data, 1'b0};
            cnt   <= 0;
            busy  <= 1'b1;
        end else if (busy) begin
            rx_out <= !frame[cnt / BIT_CLKS] && (cnt % BIT_CLKS) >= PULSE_AT && (cnt % BIT_CLKS) < PULSE_AT + PULSE_LEN;
            cnt    <= cnt + 1;
            busy   <= cnt < 10 * BIT_CLKS - 1;
        end
    end
endmodule : ir_transceiver_model
`default_nettype wire

// *** tb/uart_infrared_codec_tb.sv ***
// self-checking bench for the infrared codec
`default_nettype none
module uart_infrared_codec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ir_codec_pkg::*;
    logic             ref_clk, srst, ir_codec_enable, uart_txd, uart_rxd, baud_tick, txd_pin, rxd_pin;
    logic             tb_rx, go, busy, ir_out, pt, pr;
    logic [DIV_W-1:0] baud_divisor;
    logic [31:0]      seed = 32'h886B3844;
    logic [31:0]      r;
    logic [7:0]       data, b;
    logic [9:0]       f;
    int               fail_count = 0, n_compared = 0, n, c;
    assign rxd_pin = ir_codec_enable ? ir_out : tb_rx;
    uart_infrared_codec uut (.ref_clk, .srst, .ir_codec_enable, .baud_divisor, .uart_txd, .uart_rxd, .baud_tick,
        .txd_pin, .rxd_pin);
    ir_transceiver_model ir (.ref_clk, .srst, .go, .data, .busy, .rx_out(ir_out));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int exp_high(input logic bitv);
        return (bitv === 1'b1) ? 0 : 12; // three ticks of four clocks
    endfunction : exp_high
    task automatic finish_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic give_up();
        fail_count++;
        $display("wrong value at %0t: wait ran out", $time);
        finish_test();
    endtask : give_up
    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: line %b not %b", $time, got, exp);
        end
    endtask : check_bit
    task automatic check_count(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            fail_count++;
            $display("wrong value at %0t: count %0d not %0d", $time, got, exp);
        end
    endtask : check_count
    task automatic wait_tick(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge ref_clk);
            cnt++;
        end while (baud_tick !== 1'b1 && cnt < lim);
        if (baud_tick !== 1'b1) give_up();
    endtask : wait_tick
    // free running clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // main sequence
    initial begin
        // divisor four: exact rate, well inside the error budget, uart side assumed running
        {srst, uart_txd, tb_rx, ir_codec_enable, go, data, baud_divisor} = {3'b111, 2'b00, 8'h00, 16'h0004};
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        wait_tick(70000, n);
        wait_tick(64, n);
        check_count(n, 4);
        // codec off: both lines pass straight through
        for (int i = 0; i < 200; i++) begin
            @(posedge ref_clk);
            r = rnd();
            uart_txd <= r[0] | (i > 196);
            tb_rx    <= r[1] | (i > 196);
            @(negedge ref_clk);
            if (i > 0) check_bit(txd_pin, pt);
            if (i > 0) check_bit(uart_rxd, pr);
            pt = r[0] | (i > 196);
            pr = r[1] | (i > 196);
        end
        ir_codec_enable <= 1'b1;
        repeat (300) @(posedge ref_clk);
        // codec on: frames out through the encoder
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            f = {1'b1, (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : r[7:0], 1'b0};
            wait_tick(64, n);
            for (int j = 0; j < 10; j++) begin
                @(posedge ref_clk);
                uart_txd <= f[j];
                c = 0;
                repeat (64) @(negedge ref_clk) c += int'(txd_pin === 1'b1);
                check_count(c, exp_high(f[j]));
            end
            repeat (300) @(posedge ref_clk);
        end
        // codec on: frames in through the decoder
        for (int k = 0; k < 4; k++) begin
            r = rnd();
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : r[7:0];
            f = {1'b1, b, 1'b0};
            @(posedge ref_clk);
            data <= b;
            go   <= 1'b1;
            @(posedge ref_clk);
            go <= 1'b0;
            n = 0;
            do begin
                @(negedge ref_clk);
                n++;
            end while (uart_rxd !== 1'b0 && n < 3000);
            if (uart_rxd !== 1'b0) give_up();
            repeat (32) @(negedge ref_clk);
            for (int j = 0; j < 10; j++) begin
                check_bit(uart_rxd, f[j]);
                repeat (64) @(negedge ref_clk);
            end
            repeat (300) @(posedge ref_clk);
        end
        finish_test();
    end
endmodule : uart_infrared_codec_tb
`default_nettype wire
